// File: hdl/sps_pkg.sv
package sps_pkg;
  // command opcodes
  localparam logic [7:0] CMD_ECC_RD = 8'h18;
  localparam logic [7:0] CMD_MODE_RD = 8'h2b;
  localparam logic [7:0] CMD_MODE_PRG = 8'h2f;
  localparam logic [7:0] CMD_KEY_RD = 8'he7;
  localparam logic [7:0] CMD_KEY_PRG = 8'he8;
  localparam logic [7:0] CMD_LOCK_RD = 8'ha7;
  localparam logic [7:0] CMD_LOCK_WR = 8'ha6;
  localparam logic [7:0] CMD_PPB_RD = 8'he2;
  localparam logic [7:0] CMD_PPB_PRG = 8'he3;
  localparam logic [7:0] CMD_PPB_ERS = 8'he4;
  // field positions
  localparam int MODE_PWD_BIT = 2;
  localparam int MODE_PST_BIT = 1;
  localparam int LOCK_BIT = 0;
  localparam int ECC_UNIT_LSB = 4;
  // values after power-up, and read-back byte codes
  localparam logic [15:0] MODE_CFG_RST = 16'hffff;
  localparam logic [63:0] KEY_RST = 64'hffff_ffff_ffff_ffff;
  localparam logic [7:0] PPB_PROT = 8'h00;
  localparam logic [7:0] PPB_OPEN = 8'hff;
  localparam logic [7:0] KEY_HIDDEN = 8'hff;
  // byte counts of each phase, last bit index of a byte
  localparam logic [3:0] ADDR_BYTES = 4'h3;
  localparam logic [3:0] MODE_BYTES = 4'h2;
  localparam logic [3:0] KEY_BYTES = 4'h8;
  localparam logic [3:0] LOCK_BYTES = 4'h1;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [1:0] {ST_CMD, ST_ADDR, ST_DATA, ST_SKIP} sps_state_t;
endpackage

// File: hdl/sps_byte_if.sv
`timescale 1ns/1ps
interface sps_byte_if;
  logic frame_start; // cs went active
  logic frame_end; // cs went inactive
  logic rx_valid; // whole byte received
  logic [7:0] rx_byte;
  logic [7:0] tx_byte; // next byte to shift out
  logic tx_en; // drive so during this frame
  modport shifter(output frame_start, frame_end, rx_valid, rx_byte,
                  input tx_byte, tx_en);
  modport decoder(input frame_start, frame_end, rx_valid, rx_byte,
                  output tx_byte, tx_en);
endinterface

// File: hdl/sps_spi_shift.sv
`timescale 1ns/1ps
module sps_spi_shift
  import sps_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic rst, // async reset, active high
  input wire logic sclk_pin, // serial clock pin
  input wire logic cs_n_pin, // chip select pin, active low
  input wire logic si_pin, // serial data in pin
  output logic so, // serial data out
  output logic so_oe, // so output enable
  sps_byte_if.shifter bus // byte side
);
  logic [2:0] meta_r, meta_nxt; // {cs_n, sclk, si}, first stage
  logic [2:0] sync_r, sync_nxt;
  logic [1:0] prev_r, prev_nxt; // {cs_n, sclk} one cycle older
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, out_r, out_nxt, rxb_r, rxb_nxt;
  logic so_r, so_nxt, rxv_r, rxv_nxt, fs_r, fs_nxt, fe_r, fe_nxt;
  logic act, rise, fall;

  // edges found on the second stage only; first stage feeds nothing else
  always_comb begin
    meta_nxt = {cs_n_pin, sclk_pin, si_pin};
    sync_nxt = meta_r;
    prev_nxt = sync_r[2:1];
    act = ~sync_r[2];
    rise = act & ~prev_r[0] & sync_r[1];
    fall = act & prev_r[0] & ~sync_r[1];
    fs_nxt = prev_r[1] & ~sync_r[2];
    fe_nxt = ~prev_r[1] & sync_r[2];
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    rxb_nxt = rxb_r;
    rxv_nxt = 1'b0;
    out_nxt = out_r;
    so_nxt = so_r;
    if (fs_nxt) begin
      cnt_nxt = 3'h0;
    end else if (rise) begin
      sh_nxt = {sh_r[6:0], sync_r[0]};
      cnt_nxt = 3'(cnt_r + 3'h1);
      if (cnt_r == BIT_LAST) begin
        rxv_nxt = 1'b1;
        rxb_nxt = {sh_r[6:0], sync_r[0]};
      end
    end
    // mode 0: change data on the falling edge, msb first
    if (fall) begin
      if (cnt_r == 3'h0) begin
        so_nxt = bus.tx_byte[7];
        out_nxt = {bus.tx_byte[6:0], 1'b0};
      end else begin
        so_nxt = out_r[7];
        out_nxt = {out_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_r <= 3'h4;
      sync_r <= 3'h4;
      prev_r <= 2'h2;
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      out_r <= 8'h00;
      rxb_r <= 8'h00;
      so_r <= 1'b0;
      rxv_r <= 1'b0;
      fs_r <= 1'b0;
      fe_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      out_r <= out_nxt;
      rxb_r <= rxb_nxt;
      so_r <= so_nxt;
      rxv_r <= rxv_nxt;
      fs_r <= fs_nxt;
      fe_r <= fe_nxt;
    end
  end

  // outputs
  assign so = so_r;
  assign so_oe = ~sync_r[2] & bus.tx_en;
  assign bus.rx_valid = rxv_r;
  assign bus.rx_byte = rxb_r;
  assign bus.frame_start = fs_r;
  assign bus.frame_end = fe_r;
endmodule

// File: hdl/sps_prot_regs.sv
`timescale 1ns/1ps
module sps_prot_regs
  import sps_pkg::*;
#(
  parameter int NUM_SECTORS = 64,
  parameter int SECT_ADDR_LSB = 18
) (
  input wire logic core_clk, // core clock
  input wire logic rst, // power-on reset, async, active high
  input wire logic sclk, // serial clock pin
  input wire logic cs_n, // chip select pin, active low
  input wire logic si, // serial data in pin
  output logic so, // serial data out
  output logic so_oe, // so driven while high
  output logic [19:0] ecc_unit_addr, // unit selected for ecc status
  input wire logic ecc_chk_err, // check code error in selected unit
  input wire logic ecc_data_err, // data error corrected in unit
  input wire logic ecc_disabled, // correction off in unit
  input wire logic lock_reload, // hardware reset pulse, reloads lock
  input wire logic prog_err_clr, // clear from status register logic
  output logic prog_err, // program error flag, sticky
  output logic cfg_locked, // status two top bits locked
  output logic [NUM_SECTORS-1:0] sector_protected // 1 = sector protected
);
  localparam int SW = $clog2(NUM_SECTORS);

  sps_byte_if bus();

  sps_spi_shift u_shift (
    .core_clk(core_clk),
    .rst(rst),
    .sclk_pin(sclk),
    .cs_n_pin(cs_n),
    .si_pin(si),
    .so(so),
    .so_oe(so_oe),
    .bus(bus)
  );

  sps_state_t st_r, st_nxt;
  logic [7:0] cmd_r, cmd_nxt, tx_r, tx_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [63:0] buf_r, buf_nxt, key_r, key_nxt;
  logic [15:0] mode_r, mode_nxt;
  logic [NUM_SECTORS-1:0] ppb_r, ppb_nxt;
  logic lock_r, lock_nxt, ld_r, ld_nxt, perr_r, perr_nxt, txen_r, txen_nxt;
  logic pwd_sel, pst_sel, locked, has_addr, known, is_rd, err_set;
  logic [SW-1:0] sector;

  // mode decode; locked once either bit is cleared
  always_comb begin
    pwd_sel = ~mode_r[MODE_PWD_BIT];
    pst_sel = ~mode_r[MODE_PST_BIT];
    locked = pwd_sel | pst_sel;
    sector = addr_r[SECT_ADDR_LSB +: SW];
    has_addr = (cmd_r == CMD_ECC_RD) || (cmd_r == CMD_PPB_RD) ||
               (cmd_r == CMD_PPB_PRG);
    is_rd = (cmd_r == CMD_ECC_RD) || (cmd_r == CMD_MODE_RD) ||
            (cmd_r == CMD_KEY_RD) || (cmd_r == CMD_LOCK_RD) ||
            (cmd_r == CMD_PPB_RD);
  end

  // opcode check on the byte just received
  always_comb begin
    case (bus.rx_byte)
      CMD_ECC_RD, CMD_MODE_RD, CMD_MODE_PRG, CMD_KEY_RD, CMD_KEY_PRG,
      CMD_LOCK_RD, CMD_LOCK_WR, CMD_PPB_RD, CMD_PPB_PRG,
      CMD_PPB_ERS: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // read data for the current byte slot
  always_comb begin
    case (cmd_r)
      CMD_ECC_RD: tx_nxt = {5'h00, ecc_chk_err, ecc_data_err,
                            ecc_disabled};
      CMD_MODE_RD: tx_nxt = cnt_r[0] ? mode_r[15:8] : mode_r[7:0];
      CMD_KEY_RD: tx_nxt = pwd_sel ? KEY_HIDDEN :
                           key_r[{cnt_r[2:0], 3'b000} +: 8];
      CMD_LOCK_RD: tx_nxt = {7'h00, lock_r};
      CMD_PPB_RD: tx_nxt = ppb_r[sector] ? PPB_OPEN : PPB_PROT;
      default: tx_nxt = 8'hff;
    endcase
    txen_nxt = (st_r == ST_DATA) && is_rd && !bus.frame_start;
  end

  // command sequencer; nonvolatile updates happen at frame end only,
  // so a frame cut short never leaves a half-written register
  always_comb begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    cnt_nxt = cnt_r;
    buf_nxt = buf_r;
    mode_nxt = mode_r;
    key_nxt = key_r;
    ppb_nxt = ppb_r;
    lock_nxt = lock_r;
    ld_nxt = 1'b1;
    err_set = 1'b0;
    if (bus.frame_start) begin
      st_nxt = ST_CMD;
      cnt_nxt = 4'h0;
    end else if (bus.rx_valid) begin
      case (st_r)
        ST_CMD: begin
          cmd_nxt = bus.rx_byte;
          cnt_nxt = 4'h0;
          if (!known) begin
            st_nxt = ST_SKIP;
          end else if (bus.rx_byte == CMD_ECC_RD ||
                       bus.rx_byte == CMD_PPB_RD ||
                       bus.rx_byte == CMD_PPB_PRG) begin
            st_nxt = ST_ADDR;
          end else begin
            st_nxt = ST_DATA;
          end
        end
        ST_ADDR: begin
          addr_nxt = {addr_r[15:0], bus.rx_byte};
          cnt_nxt = 4'(cnt_r + 4'h1);
          if (cnt_r == 4'(ADDR_BYTES - 4'h1)) begin
            st_nxt = ST_DATA;
            cnt_nxt = 4'h0;
          end
        end
        ST_DATA: begin
          if (cnt_r < KEY_BYTES) begin
            buf_nxt[{cnt_r[2:0], 3'b000} +: 8] = bus.rx_byte;
            cnt_nxt = 4'(cnt_r + 4'h1);
          end
        end
        default: st_nxt = ST_SKIP;
      endcase
    end else if (bus.frame_end && st_r == ST_DATA) begin
      // leave the data phase; a stale enable would drive so at next select
      st_nxt = ST_SKIP;
      case (cmd_r)
        CMD_MODE_PRG: begin
          if (cnt_r >= MODE_BYTES) begin
            if (locked) begin
              err_set = 1'b1;
            end else begin
              mode_nxt = mode_r & buf_r[15:0];
            end
          end
        end
        CMD_KEY_PRG: begin
          if (cnt_r >= KEY_BYTES) begin
            if (locked) begin
              err_set = 1'b1;
            end else begin
              key_nxt = key_r & buf_r;
            end
          end
        end
        CMD_LOCK_WR: begin
          // writing one cannot reopen a closed lock
          if (cnt_r >= LOCK_BYTES) begin
            lock_nxt = lock_r & buf_r[LOCK_BIT];
          end
        end
        CMD_PPB_PRG: begin
          if (!lock_r || !has_addr) begin
            err_set = !lock_r;
          end else begin
            ppb_nxt[sector] = 1'b0;
          end
        end
        CMD_PPB_ERS: begin
          if (!lock_r) begin
            err_set = 1'b1;
          end else begin
            ppb_nxt = '1;
          end
        end
        default: err_set = 1'b0;
      endcase
    end
    // lock default follows the selected mode after any reset
    if (!ld_r || lock_reload) begin
      lock_nxt = ~pwd_sel;
    end
    // a new error wins over a clear in the same cycle
    perr_nxt = (perr_r & ~prog_err_clr) | err_set;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_SKIP;
      cmd_r <= 8'h00;
      addr_r <= 24'h000000;
      cnt_r <= 4'h0;
      buf_r <= 64'h0;
      mode_r <= MODE_CFG_RST;
      key_r <= KEY_RST;
      ppb_r <= '1;
      lock_r <= 1'b0;
      ld_r <= 1'b0;
      perr_r <= 1'b0;
      tx_r <= 8'hff;
      txen_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      cnt_r <= cnt_nxt;
      buf_r <= buf_nxt;
      mode_r <= mode_nxt;
      key_r <= key_nxt;
      ppb_r <= ppb_nxt;
      lock_r <= lock_nxt;
      ld_r <= ld_nxt;
      perr_r <= perr_nxt;
      tx_r <= tx_nxt;
      txen_r <= txen_nxt;
    end
  end

  // outputs
  assign bus.tx_byte = tx_r;
  assign bus.tx_en = txen_r;
  assign ecc_unit_addr = addr_r[23:ECC_UNIT_LSB];
  assign prog_err = perr_r;
  assign cfg_locked = locked;
  assign sector_protected = ~ppb_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_ecc_slot;
    st_r == ST_DATA && cmd_r == CMD_ECC_RD;
  endsequence

  sequence s_ppb_prog_ok;
    bus.frame_end && st_r == ST_DATA && cmd_r == CMD_PPB_PRG && lock_r;
  endsequence

  a_ecc_check_bit: assert property (s_ecc_slot |=>
    tx_r[2] == $past(ecc_chk_err))
    else $error("ecc check code bit wrong");
  a_ecc_data_bit: assert property (s_ecc_slot |=>
    tx_r[1] == $past(ecc_data_err))
    else $error("ecc data bit wrong");
  a_ecc_dis_bit: assert property (s_ecc_slot |=>
    tx_r[0] == $past(ecc_disabled))
    else $error("ecc disable bit wrong");
  a_ecc_rsvd_zero: assert property (s_ecc_slot |=>
    tx_r[7:3] == 5'h00)
    else $error("ecc reserved bits not zero");
  a_mode_otp_only: assert property (
    (mode_r & ~$past(mode_r)) == 16'h0000)
    else $error("mode bit went back to one");
  a_locked_frozen: assert property (locked |=>
    $stable(mode_r) && $stable(key_r))
    else $error("locked config changed");
  a_locked_prog_err: assert property (bus.frame_end && st_r == ST_DATA &&
    cmd_r == CMD_KEY_PRG && cnt_r >= KEY_BYTES && locked
    |=> perr_r [*2])
    else $error("locked program gave no error");
  a_key_hidden: assert property (pwd_sel && st_r == ST_DATA &&
    cmd_r == CMD_KEY_RD |=> tx_r == KEY_HIDDEN)
    else $error("key readable in password mode");
  a_lock_reset_val: assert property (lock_reload |=>
    lock_r == !$past(pwd_sel))
    else $error("lock reload value wrong");
  a_lock_stays_shut: assert property (!lock_r && ld_r && !lock_reload
    |=> !lock_r && $stable(ppb_r))
    else $error("closed lock reopened or bits changed");
  a_ppb_prog_clear: assert property (s_ppb_prog_ok |=>
    !ppb_r[$past(sector)])
    else $error("sector bit not programmed");
  a_ppb_read_map: assert property (st_r == ST_DATA &&
    cmd_r == CMD_PPB_RD |=> tx_r == ($past(ppb_r[sector]) ?
    PPB_OPEN : PPB_PROT))
    else $error("sector bit access byte wrong");
  a_ppb_erase_all: assert property (bus.frame_end && st_r == ST_DATA &&
    cmd_r == CMD_PPB_ERS && lock_r |=> &ppb_r)
    else $error("sector bits not all erased");
  a_err_set_wins: assert property (err_set |=> perr_r)
    else $error("program error lost");
endmodule

// File: verification/sps_host_model.sv
`timescale 1ns/1ps
module sps_host_model (
  input wire logic core_clk, // core clock, aligns frame starts only
  output logic sclk, // serial clock, still outside frames
  output logic cs_n, // chip select, active low
  output logic si, // serial data to the device
  input wire logic so // serial data from the device
);
  localparam time HALF = 40ns;

  // idle bus: clock low for mode 0, device deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // si moves while sclk is low; so is taken at the rising edge
  task automatic bit_xfer(input logic b, output logic r);
    si = b;
    #HALF;
    sclk = 1'b1;
    r = so;
    #HALF;
    sclk = 1'b0;
  endtask

  task automatic byte_xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], r[i]);
  endtask

  // command, optional 24-bit address msb first, data bytes byte0 first
  task automatic frame(input logic [7:0] cmd, input logic use_adr,
                       input logic [23:0] adr, input int nbytes,
                       input logic [63:0] wdata, output logic [63:0] rdata);
    logic [7:0] r;
    rdata = 64'h0;
    @(posedge core_clk);
    #1;
    cs_n = 1'b0;
    #HALF;
    byte_xfer(cmd, r);
    if (use_adr)
      for (int i = 2; i >= 0; i--) byte_xfer(adr[8*i +: 8], r);
    for (int i = 0; i < nbytes; i++) begin
      byte_xfer(wdata[8*i +: 8], r);
      rdata[8*i +: 8] = r;
    end
    #HALF;
    cs_n = 1'b1;
    // a released line must not keep showing the last bit
    si = ~si;
    #(2*HALF);
  endtask
endmodule

// File: verification/tb_sps_prot_regs.sv
`timescale 1ns/1ps
module tb_sps_prot_regs import sps_pkg::*;;
  logic core_clk, rst, sclk, cs_n, si, so, so_oe, prog_err, cfg_locked;
  logic ecc_chk_err, ecc_data_err, ecc_disabled, lock_reload, prog_err_clr;
  logic [19:0] ecc_unit_addr;
  logic [63:0] sector_protected;
  logic [63:0] d;
  logic [23:0] a;
  int fails = 0;
  int n_compared = 0;
  int oe_cnt = 0;
  int n0;

  sps_prot_regs #(.NUM_SECTORS(64), .SECT_ADDR_LSB(18)) dut (
    .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si),
    .so(so), .so_oe(so_oe), .ecc_unit_addr(ecc_unit_addr),
    .ecc_chk_err(ecc_chk_err), .ecc_data_err(ecc_data_err),
    .ecc_disabled(ecc_disabled), .lock_reload(lock_reload),
    .prog_err_clr(prog_err_clr), .prog_err(prog_err),
    .cfg_locked(cfg_locked), .sector_protected(sector_protected));

  sps_host_model host (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n),
    .si(si), .so(so));

  // cycles with so driven; only read frames may add to it
  always @(posedge core_clk) if (so_oe === 1'b1) oe_cnt++;

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // address phase only for the commands that carry one
  task automatic xf(input logic [7:0] cmd, input logic [23:0] adr,
                    input int n, input logic [63:0] w);
    logic use_adr;
    use_adr = (cmd == CMD_ECC_RD || cmd == CMD_PPB_RD || cmd == CMD_PPB_PRG);
    host.frame(cmd, use_adr, adr, n, w, d);
  endtask

  // one-cycle pulse on {lock_reload, prog_err_clr}
  task automatic pulse(input logic [1:0] s);
    @(posedge core_clk);
    #1 {lock_reload, prog_err_clr} = s;
    @(posedge core_clk);
    #1 {lock_reload, prog_err_clr} = 2'b00;
  endtask

  task automatic power_cycle;
    @(posedge core_clk);
    #1 rst = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // cut a hang short; the whole run needs well under half of this
  initial begin
    #400_000;
    fails++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    {ecc_chk_err, ecc_data_err, ecc_disabled} = 3'h0;
    lock_reload = 1'b0;
    prog_err_clr = 1'b0;
    repeat (12) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge core_clk);

    // power-up values
    n0 = oe_cnt;
    xf(CMD_MODE_RD, 24'h0, 2, 64'h0); chk(d[15:0], MODE_CFG_RST);
    chk(64'(oe_cnt > n0), 64'h1);
    xf(CMD_KEY_RD, 24'h0, 8, 64'h0); chk(d, KEY_RST);
    xf(CMD_LOCK_RD, 24'h0, 1, 64'h0); chk(d[7:0], 8'h01);
    xf(CMD_PPB_RD, 24'hfc0000, 1, 64'h0); chk(d[7:0], PPB_OPEN);
    chk(cfg_locked, 1'b0);
    chk(so_oe, 1'b0);
    $display("test defaults done");

    // every combination of the three status conditions
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk);
      #1 {ecc_chk_err, ecc_data_err, ecc_disabled} = k[2:0];
      a = 24'h9c3003 | 24'(k * 16);
      xf(CMD_ECC_RD, a, 1, 64'h0);
      // upper five bits are don't care, only the low three compared
      chk(d[2:0], k[2:0]);
      chk(ecc_unit_addr, a[23:4]);
    end
    $display("test ecc status done");

    // top sector programmed, neighbour untouched, erase clears all
    n0 = oe_cnt;
    xf(CMD_PPB_PRG, 24'hfc0000, 0, 64'h0);
    chk(64'(oe_cnt - n0), 64'h0);
    chk(sector_protected, 64'h8000_0000_0000_0000);
    xf(CMD_PPB_RD, 24'hfc1234, 1, 64'h0); chk(d[7:0], PPB_PROT);
    xf(CMD_PPB_RD, 24'hf80000, 1, 64'h0); chk(d[7:0], PPB_OPEN);
    xf(CMD_PPB_ERS, 24'h0, 0, 64'h0); chk(sector_protected, 64'h0);
    chk(prog_err, 1'b0);
    $display("test sector bits done");

    // key programmed while no mode chosen yet
    xf(CMD_KEY_PRG, 24'h0, 8, 64'h0123_4567_89ab_cdef);
    xf(CMD_KEY_RD, 24'h0, 8, 64'h0);
    chk(d, 64'h0123_4567_89ab_cdef);
    $display("test key done");

    // lock closed: sector change refused until hardware reset
    xf(CMD_LOCK_WR, 24'h0, 1, 64'h0);
    xf(CMD_LOCK_RD, 24'h0, 1, 64'h0); chk(d[7:0], 8'h00);
    xf(CMD_PPB_PRG, 24'h000000, 0, 64'h0);
    chk(sector_protected, 64'h0);
    chk(prog_err, 1'b1);
    pulse(2'b01);
    chk(prog_err, 1'b0);
    pulse(2'b10);
    xf(CMD_LOCK_RD, 24'h0, 1, 64'h0); chk(d[7:0], 8'h01);
    xf(CMD_PPB_PRG, 24'h000000, 0, 64'h0);
    chk(sector_protected, 64'h1);
    xf(CMD_PPB_ERS, 24'h0, 0, 64'h0);
    $display("test lock done");

    // password mode chosen last, after all one-time setup
    xf(CMD_MODE_PRG, 24'h0, 2, 64'hfffb);
    xf(CMD_MODE_RD, 24'h0, 2, 64'h0); chk(d[15:0], 16'hfffb);
    chk(cfg_locked, 1'b1);
    xf(CMD_KEY_RD, 24'h0, 8, 64'h0); chk(d, {8{KEY_HIDDEN}});
    xf(CMD_PPB_PRG, 24'h000000, 0, 64'h0);
    chk(sector_protected, 64'h1);
    pulse(2'b10);
    xf(CMD_LOCK_RD, 24'h0, 1, 64'h0); chk(d[7:0], 8'h00);
    // writing one must not reopen the lock
    xf(CMD_LOCK_WR, 24'h0, 1, 64'h1);
    xf(CMD_LOCK_RD, 24'h0, 1, 64'h0); chk(d[7:0], 8'h00);
    xf(CMD_PPB_ERS, 24'h0, 0, 64'h0);
    chk(sector_protected, 64'h1);
    chk(prog_err, 1'b1);
    pulse(2'b01);
    xf(CMD_KEY_PRG, 24'h0, 8, 64'h0);
    chk(prog_err, 1'b1);
    pulse(2'b01);
    xf(CMD_MODE_PRG, 24'h0, 2, 64'hfff9);
    chk(prog_err, 1'b1);
    xf(CMD_MODE_RD, 24'h0, 2, 64'h0); chk(d[15:0], 16'hfffb);
    $display("test password mode done");

    // power cycle back to defaults, then persistent mode
    power_cycle();
    xf(CMD_MODE_RD, 24'h0, 2, 64'h0); chk(d[15:0], MODE_CFG_RST);
    xf(CMD_MODE_PRG, 24'h0, 2, 64'hfffd);
    xf(CMD_MODE_RD, 24'h0, 2, 64'h0); chk(d[15:0], 16'hfffd);
    chk(cfg_locked, 1'b1);
    xf(CMD_KEY_PRG, 24'h0, 8, 64'h0);
    chk(prog_err, 1'b1);
    xf(CMD_KEY_RD, 24'h0, 8, 64'h0); chk(d, KEY_RST);
    pulse(2'b10);
    xf(CMD_LOCK_RD, 24'h0, 1, 64'h0); chk(d[7:0], 8'h01);
    $display("test persistent mode done");
    close_out();
  end
endmodule
